// [verilog/pid_process_regulator.sv]
// Purpose: process pid regulator producing a signed frequency reference
// Assumes: setpoint and feedback come from logic on sys_clk, 0..FULL_SCALE
// Notes: all settings are plain inputs; only the switch terminal is a pin
//
// Function
// - derivative: full-scale feedback change within derivative time gives max frequency
// - negative output magnitude clamped to reverse cut-off frequency, default zero
// - deviation below deadband suspends regulation, output held steady
// - derivative contribution saturated to the derivative clamp setting
// - setpoint ramps linearly, full range in ramp time; zero is immediate
// - feedback low-pass filtered with its own time constant
// - output frequency low-pass filtered with its own time constant
// - second gain group interpreted exactly like the first
// - switch condition: 0 none, 1 terminal, 2 automatic on deviation
// - terminal mode: terminal off selects group a, on selects group b
// - automatic mode: deviation below low threshold selects group a
// - automatic mode: deviation above high threshold selects group b
// - between thresholds each gain is linearly interpolated
// - on start output forced to initial value for hold time
// - gain 100.0 with full-scale deviation adjusts by max frequency
// - full-scale deviation over integral time integrates to max frequency
// - polarity 0 raises output on low feedback, 1 lowers it
`timescale 1ns/10ps
module pid_process_regulator #(
  parameter int SAMPLE_CYCLES = pid_regulator_pkg::SAMPLE_CYCLES_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic run,
  input wire logic gain_switch_terminal,
  input wire logic [15:0] setpoint,
  input wire logic [15:0] feedback,
  input wire pid_regulator_pkg::pid_config_type cfg,
  output logic signed [15:0] freq_ref,
  output logic signed [15:0] effective_setpoint,
  output logic signed [15:0] filtered_feedback,
  output logic startup_active,
  output logic deviation_hold
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clamp to +/- full scale
  function automatic logic signed [31:0] sat_full(input logic signed [31:0] v);
    logic signed [31:0] r;
    r = v;
    if (v > 32'(pid_regulator_pkg::FULL_SCALE)) begin
      r = 32'(pid_regulator_pkg::FULL_SCALE);
    end else if (v < -32'(pid_regulator_pkg::FULL_SCALE)) begin
      r = -32'(pid_regulator_pkg::FULL_SCALE);
    end
    return r;
  endfunction : sat_full

  // one first-order step; acc carries FRAC_BITS of fraction
  function automatic logic signed [31:0] lpf_step(input logic signed [31:0] acc,
                                                   input logic signed [31:0] x, input logic [12:0] tc);
    logic signed [31:0] div;
    div = 32'(tc) * 32'(pid_regulator_pkg::SAMPLES_PER_CS) + 32'sd1;
    return acc + ((x <<< pid_regulator_pkg::FRAC_BITS) - acc) / div;
  endfunction : lpf_step

  // linear blend, w runs 0..WEIGHT_ONE; signed casts stop a falling blend (b below a) from wrapping
  function automatic logic signed [31:0] blend(input logic [13:0] a, input logic [13:0] b,
                                                input logic signed [31:0] w);
    return $signed(32'(a)) + (($signed(32'(b)) - $signed(32'(a))) * w) / 32'(pid_regulator_pkg::WEIGHT_ONE);
  endfunction : blend

  // permil setting to fraction of full scale
  function automatic logic signed [31:0] permil_frac(input logic [9:0] v);
    return (32'(v) * 32'(pid_regulator_pkg::FULL_SCALE)) / 32'(pid_regulator_pkg::PERMIL);
  endfunction : permil_frac

  // ----------------------------------------------------------------
  // terminal synchroniser and sample tick
  // ----------------------------------------------------------------
  logic term_meta_q, term_meta_d;
  logic term_sync_q, term_sync_d;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic sample_tick;

  // the pin is asynchronous, so two flops before use
  always_comb begin
    term_meta_d = gain_switch_terminal;
    term_sync_d = term_meta_q;
    sample_tick = (tick_cnt_q == 32'(SAMPLE_CYCLES - 1));
    tick_cnt_d = sample_tick ? 32'h0 : tick_cnt_q + 32'h1;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      term_meta_q <= 1'b0;
      term_sync_q <= 1'b0;
      tick_cnt_q <= 32'h0;
    end else if (clk_en) begin
      term_meta_q <= term_meta_d;
      term_sync_q <= term_sync_d;
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // regulator state
  // ----------------------------------------------------------------
  pid_regulator_pkg::reg_state_type state_q, state_d;
  logic [31:0] hold_cnt_q, hold_cnt_d;
  logic signed [31:0] sp_q, sp_d;
  logic signed [31:0] fb_acc_q, fb_acc_d;
  logic signed [31:0] fb_prev_q, fb_prev_d;
  logic signed [31:0] integ_q, integ_d;
  logic signed [31:0] out_acc_q, out_acc_d;
  logic signed [15:0] freq_ref_q, freq_ref_d;
  logic hold_flag_q, hold_flag_d;

  // working values
  logic signed [31:0] sp_step, sp_target, fb_now, dev, dev_abs, fb_delta;
  logic signed [31:0] thr_lo, thr_hi, weight, db_frac, clamp_frac, rev_frac;
  logic signed [31:0] kp, ti, td, p_term, i_inc, d_term, u, u_lim, init_frac;
  logic use_b;

  // gain selection and scaling of the settings
  always_comb begin
    init_frac = permil_frac(cfg.startup_output_value);
    sp_target = 32'(setpoint);
    fb_now = fb_acc_q >>> pid_regulator_pkg::FRAC_BITS;
    if (cfg.polarity) begin
      dev = fb_now - sp_q;
    end else begin
      dev = sp_q - fb_now;
    end
    dev_abs = (dev < 0) ? -dev : dev;
    thr_hi = permil_frac(cfg.switch_threshold_high);
    thr_lo = permil_frac(cfg.switch_threshold_low);
    if (thr_lo > thr_hi) begin
      thr_lo = thr_hi;
    end
    use_b = 1'b0;
    weight = 32'sd0;
    case (cfg.gain_switch_condition)
      pid_regulator_pkg::SWITCH_NONE: begin
        weight = 32'sd0;
      end
      pid_regulator_pkg::SWITCH_TERMINAL: begin
        use_b = term_sync_q;
        weight = use_b ? 32'(pid_regulator_pkg::WEIGHT_ONE) : 32'sd0;
      end
      pid_regulator_pkg::SWITCH_AUTO: begin
        if (dev_abs < thr_lo || thr_hi == thr_lo) begin
          weight = (dev_abs > thr_hi) ? 32'(pid_regulator_pkg::WEIGHT_ONE) : 32'sd0;
        end else if (dev_abs > thr_hi) begin
          weight = 32'(pid_regulator_pkg::WEIGHT_ONE);
        end else begin
          weight = ((dev_abs - thr_lo) * 32'(pid_regulator_pkg::WEIGHT_ONE)) / (thr_hi - thr_lo);
        end
      end
      default: begin
        weight = 32'sd0;
      end
    endcase
    // group b fields read through the same path as group a
    kp = blend(14'(cfg.gain_a.prop_gain), 14'(cfg.gain_b.prop_gain), weight);
    ti = blend(14'(cfg.gain_a.integ_time), 14'(cfg.gain_b.integ_time), weight);
    td = blend(cfg.gain_a.deriv_time, cfg.gain_b.deriv_time, weight);
    if (ti < 32'sd1) begin
      ti = 32'sd1; // a zero integral time would divide by zero
    end
    db_frac = permil_frac(cfg.deviation_deadband);
    clamp_frac = (32'(cfg.derivative_clamp) * 32'(pid_regulator_pkg::FULL_SCALE))
                 / 32'(pid_regulator_pkg::PER_TEN_THOUSAND);
    if (cfg.max_freq == 16'h0000) begin
      rev_frac = 32'sd0;
    end else begin
      rev_frac = sat_full((32'(cfg.reverse_cutoff_freq) * 32'(pid_regulator_pkg::FULL_SCALE))
                          / 32'(cfg.max_freq));
    end
  end

  // control terms of one sample
  always_comb begin
    // ramp step per sample; full range over the ramp time
    if (cfg.setpoint_ramp_time == 16'h0000) begin
      sp_step = 32'(pid_regulator_pkg::FULL_SCALE);
    end else begin
      sp_step = 32'(pid_regulator_pkg::FULL_SCALE)
                / (32'(cfg.setpoint_ramp_time) * 32'(pid_regulator_pkg::SAMPLES_PER_CS));
      if (sp_step < 32'sd1) begin
        sp_step = 32'sd1; // very long ramps degrade to one lsb per sample
      end
    end
    p_term = (dev * kp) / 32'(pid_regulator_pkg::PERMIL);
    i_inc = (dev <<< pid_regulator_pkg::FRAC_BITS) / (ti * 32'(pid_regulator_pkg::SAMPLES_PER_CS));
    // derivative acts on the feedback so a setpoint step gives no kick
    fb_delta = fb_now - fb_prev_q;
    d_term = (fb_delta * td) * 32'(pid_regulator_pkg::SAMPLES_PER_MS);
    if (!cfg.polarity) begin
      d_term = -d_term;
    end
    if (d_term > clamp_frac) begin
      d_term = clamp_frac;
    end else if (d_term < -clamp_frac) begin
      d_term = -clamp_frac;
    end
    u = sat_full(p_term + (integ_q >>> pid_regulator_pkg::FRAC_BITS) + d_term);
    u_lim = (u < -rev_frac) ? -rev_frac : u;
  end

  // sequence and state update, only on sample ticks
  always_comb begin
    state_d = state_q;
    hold_cnt_d = hold_cnt_q;
    sp_d = sp_q;
    fb_acc_d = fb_acc_q;
    fb_prev_d = fb_prev_q;
    integ_d = integ_q;
    out_acc_d = out_acc_q;
    freq_ref_d = freq_ref_q;
    hold_flag_d = hold_flag_q;
    if (sample_tick) begin
      fb_acc_d = lpf_step(fb_acc_q, 32'(feedback), cfg.feedback_filter_tc);
      fb_prev_d = fb_now;
      if (sp_target > sp_q + sp_step) begin
        sp_d = sp_q + sp_step;
      end else if (sp_target < sp_q - sp_step) begin
        sp_d = sp_q - sp_step;
      end else begin
        sp_d = sp_target;
      end
      case (state_q)
        pid_regulator_pkg::ST_IDLE: begin
          integ_d = 32'sd0;
          out_acc_d = 32'sd0;
          freq_ref_d = pid_regulator_pkg::FREQ_REF_RESET;
          hold_flag_d = 1'b0;
          if (run) begin
            hold_cnt_d = 32'(cfg.startup_hold_time) * 32'(pid_regulator_pkg::SAMPLES_PER_CS);
            state_d = pid_regulator_pkg::ST_HOLD;
          end
        end
        pid_regulator_pkg::ST_HOLD: begin
          // output pinned; integrator preset so the handover is bumpless
          freq_ref_d = 16'(init_frac);
          out_acc_d = init_frac <<< pid_regulator_pkg::FRAC_BITS;
          integ_d = init_frac <<< pid_regulator_pkg::FRAC_BITS;
          if (!run) begin
            state_d = pid_regulator_pkg::ST_IDLE;
          end else if (hold_cnt_q == 32'h0) begin
            state_d = pid_regulator_pkg::ST_REGULATE;
          end else begin
            hold_cnt_d = hold_cnt_q - 32'h1;
          end
        end
        pid_regulator_pkg::ST_REGULATE: begin
          if (!run) begin
            state_d = pid_regulator_pkg::ST_IDLE;
          end else if (dev_abs < db_frac) begin
            hold_flag_d = 1'b1;
          end else begin
            hold_flag_d = 1'b0;
            integ_d = integ_q + i_inc;
            if (integ_d > (32'(pid_regulator_pkg::FULL_SCALE) <<< pid_regulator_pkg::FRAC_BITS)) begin
              integ_d = 32'(pid_regulator_pkg::FULL_SCALE) <<< pid_regulator_pkg::FRAC_BITS;
            end else if (integ_d < -(32'(pid_regulator_pkg::FULL_SCALE) <<< pid_regulator_pkg::FRAC_BITS)) begin
              integ_d = -(32'(pid_regulator_pkg::FULL_SCALE) <<< pid_regulator_pkg::FRAC_BITS);
            end
            out_acc_d = lpf_step(out_acc_q, u_lim, cfg.output_filter_tc);
            freq_ref_d = 16'(out_acc_d >>> pid_regulator_pkg::FRAC_BITS);
          end
        end
        default: begin
          state_d = pid_regulator_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= pid_regulator_pkg::ST_IDLE;
      hold_cnt_q <= 32'h0;
      sp_q <= 32'sh0;
      fb_acc_q <= 32'sh0;
      fb_prev_q <= 32'sh0;
      integ_q <= 32'sh0;
      out_acc_q <= 32'sh0;
      freq_ref_q <= pid_regulator_pkg::FREQ_REF_RESET;
      hold_flag_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      hold_cnt_q <= hold_cnt_d;
      sp_q <= sp_d;
      fb_acc_q <= fb_acc_d;
      fb_prev_q <= fb_prev_d;
      integ_q <= integ_d;
      out_acc_q <= out_acc_d;
      freq_ref_q <= freq_ref_d;
      hold_flag_q <= hold_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign freq_ref = freq_ref_q;
  assign effective_setpoint = 16'(sp_q);
  assign filtered_feedback = 16'(fb_now);
  assign startup_active = (state_q == pid_regulator_pkg::ST_HOLD);
  assign deviation_hold = hold_flag_q;

endmodule : pid_process_regulator

// [shared/pid_regulator_pkg.sv]
// Purpose: constants and carrier types for the process pid regulator
// Assumes: fractions are signed, FULL_SCALE stands for 100.0 percent
// Notes: setting units are the panel units (0.1, 0.01 or 0.001)
package pid_regulator_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SAMPLE_TIME_US = 1000;
  localparam int SAMPLE_CYCLES_DEFAULT = (SAMPLE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int MILLISEC_US = 1000;
  localparam int CENTISEC_US = 10000;
  // samples per setting step; the sample period must divide both
  localparam int SAMPLES_PER_MS = MILLISEC_US / SAMPLE_TIME_US;
  localparam int SAMPLES_PER_CS = CENTISEC_US / SAMPLE_TIME_US;

  // ----------------------------------------------------------------
  // fixed point scaling
  // ----------------------------------------------------------------
  localparam int FRAC_BITS = 8;
  localparam int FULL_SCALE = 16384;
  localparam int PERMIL = 1000;
  localparam int PER_TEN_THOUSAND = 10000;
  localparam int WEIGHT_ONE = 256;
  localparam logic signed [15:0] FREQ_REF_RESET = 16'sh0000;
  localparam logic [1:0] SWITCH_NONE = 2'h0;
  localparam logic [1:0] SWITCH_TERMINAL = 2'h1;
  localparam logic [1:0] SWITCH_AUTO = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_REGULATE = 2'b10
  } reg_state_type;

  typedef struct packed {
    logic [9:0] prop_gain;    // 0.1 units, 0..1000
    logic [9:0] integ_time;   // 0.01 s units, 1..1000
    logic [13:0] deriv_time;  // 0.001 s units, 0..10000
  } gain_set_type;

  typedef struct packed {
    gain_set_type gain_a;
    gain_set_type gain_b;
    logic polarity;                     // 0 positive, 1 negative
    logic [1:0] gain_switch_condition;
    logic [15:0] max_freq;              // 0.01 Hz units
    logic [15:0] reverse_cutoff_freq;   // 0.01 Hz units
    logic [9:0] deviation_deadband;     // 0.1 percent
    logic [13:0] derivative_clamp;      // 0.01 percent
    logic [15:0] setpoint_ramp_time;    // 0.01 s
    logic [12:0] feedback_filter_tc;    // 0.01 s
    logic [12:0] output_filter_tc;      // 0.01 s
    logic [9:0] switch_threshold_low;   // 0.1 percent
    logic [9:0] switch_threshold_high;  // 0.1 percent
    logic [9:0] startup_output_value;   // 0.1 percent
    logic [15:0] startup_hold_time;     // 0.01 s
  } pid_config_type;

endpackage : pid_regulator_pkg

// [verification/pid_regulator_props.sv]
// Purpose: port assertions for the process regulator
// Assumes: SAMPLE_CYCLES equals the bound instance's
// Notes: a tick mirror follows the design's counter
`timescale 1ns/10ps
module pid_regulator_props #(
  parameter int SAMPLE_CYCLES = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic run,
  input wire logic gain_switch_terminal,
  input wire logic [15:0] setpoint,
  input wire logic [15:0] feedback,
  input wire pid_regulator_pkg::pid_config_type cfg,
  input wire logic signed [15:0] freq_ref,
  input wire logic signed [15:0] effective_setpoint,
  input wire logic signed [15:0] filtered_feedback,
  input wire logic startup_active,
  input wire logic deviation_hold
);
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] hold_q;
  logic [31:0] hold_d;
  logic tick;
  int init_v;
  int rev_lim;
  int step;
  int hold_max;
  // mirror freezes with clk_en so tick phase never drifts
  always_comb begin
    tick = clk_en && (cnt_q == SAMPLE_CYCLES - 1);
    cnt_d = !clk_en ? cnt_q : (tick ? 32'h0 : cnt_q + 32'h1);
    hold_d = !startup_active ? 32'h0 : (clk_en ? hold_q + 32'h1 : hold_q);
    init_v = int'(cfg.startup_output_value) * 16384 / 1000;
    rev_lim = (cfg.max_freq == 16'h0) ? 0 : int'(cfg.reverse_cutoff_freq) * 16384 / int'(cfg.max_freq);
    step = (cfg.setpoint_ramp_time == 16'h0) ? 0 : 16384 / (int'(cfg.setpoint_ramp_time) * 10);
    step = (step < 1) ? 1 : step;
    hold_max = (int'(cfg.startup_hold_time) * 10 + 1) * SAMPLE_CYCLES;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 32'h0;
      hold_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
      hold_q <= hold_d;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  property p_reset_vals;
    $fell(reset) |-> freq_ref == 16'sh0 && effective_setpoint == 16'sh0 && !startup_active && !deviation_hold;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared by reset");
  property p_tick_only;
    $changed(freq_ref) || $changed(effective_setpoint) |-> $past(tick);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("output moved off a sample tick");
  property p_reverse;
    freq_ref < 16'sh0 |-> (0 - int'(freq_ref)) <= rev_lim;
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse output above cut-off");
  property p_dead_hold;
    deviation_hold |-> $stable(freq_ref);
  endproperty
  a_dead_hold: assert property (p_dead_hold) else $error("output moved in dead band");
  property p_dead_idle;
    deviation_hold |-> !startup_active;
  endproperty
  a_dead_idle: assert property (p_dead_idle) else $error("dead band flagged during start hold");
  property p_hold_val;
    hold_q >= SAMPLE_CYCLES |-> int'(freq_ref) == init_v;
  endproperty
  a_hold_val: assert property (p_hold_val) else $error("start output not at initial value");
  property p_hold_len;
    startup_active |-> hold_q < hold_max;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("start hold too long");
  property p_ramp;
    $changed(effective_setpoint) && cfg.setpoint_ramp_time != 16'h0
      |-> (effective_setpoint - $past(effective_setpoint)) <= step
      && (effective_setpoint - $past(effective_setpoint)) >= -step;
  endproperty
  a_ramp: assert property (p_ramp) else $error("setpoint step above ramp rate");
  property p_freeze;
    !clk_en |=> $stable(freq_ref) && $stable(effective_setpoint) && $stable(startup_active);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
  property p_fb_pass;
    $past(tick) && cfg.feedback_filter_tc == 13'h0 |-> filtered_feedback == $past(feedback);
  endproperty
  a_fb_pass: assert property (p_fb_pass) else $error("unfiltered feedback differs");
endmodule : pid_regulator_props

bind pid_process_regulator pid_regulator_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) props_i (
  .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .run(run),
  .gain_switch_terminal(gain_switch_terminal), .setpoint(setpoint), .feedback(feedback),
  .cfg(cfg), .freq_ref(freq_ref), .effective_setpoint(effective_setpoint),
  .filtered_feedback(filtered_feedback), .startup_active(startup_active),
  .deviation_hold(deviation_hold));

// [verification/drive_side_model.sv]
// Purpose: terminal side of the drive for the regulator
// Assumes: terminal is a plain level, no bounce
// Notes: lag makes the level land late, as a slow input would
`timescale 1ns/10ps
module drive_side_model (
  input wire logic sys_clk,
  input wire logic want_on,
  input wire logic [3:0] lag,
  output logic gain_switch_terminal
);
  logic [3:0] wait_q = 4'h0;
  initial gain_switch_terminal = 1'b0;
  // the outside party owns the switch-over terminal level
  always @(posedge sys_clk) begin
    if (want_on == gain_switch_terminal) wait_q <= 4'h0;
    else if (wait_q >= lag) gain_switch_terminal <= want_on;
    else wait_q <= wait_q + 4'h1;
  end
endmodule : drive_side_model

// [verification/testbench.sv]
// Purpose: self-checking bench for the process regulator
// Assumes: sample period shortened to SC clocks
// Notes: integral time kept long so P dominates the check
`timescale 1ns/10ps
module testbench;
  localparam int SC = 8;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic run = 1'b0;
  logic want_on = 1'b0;
  logic [3:0] lag = 4'h0;
  logic term;
  logic [15:0] setpoint = 16'h0000;
  logic [15:0] feedback = 16'h0000;
  pid_regulator_pkg::pid_config_type cfg = '0;
  logic signed [15:0] freq_ref;
  logic signed [15:0] eff_sp;
  logic signed [15:0] filt_fb;
  logic startup_active;
  logic deviation_hold;
  int errors = 0;
  int checks_done = 0;
  always #2 sys_clk = ~sys_clk;
  drive_side_model model_i (.sys_clk(sys_clk), .want_on(want_on), .lag(lag), .gain_switch_terminal(term));
  pid_process_regulator #(.SAMPLE_CYCLES(SC)) DUT (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .run(run), .gain_switch_terminal(term),
    .setpoint(setpoint), .feedback(feedback), .cfg(cfg), .freq_ref(freq_ref),
    .effective_setpoint(eff_sp), .filtered_feedback(filt_fb),
    .startup_active(startup_active), .deviation_hold(deviation_hold));
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic complete_run();
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // tolerance covers integrator creep and integer rounding
  task automatic check(input logic signed [31:0] seen, input logic signed [31:0] exp, input int tol = 0);
    logic signed [31:0] d;
    logic ok;
    d = seen - exp;
    ok = 1'b0;
    checks_done++;
    if (seen === exp) ok = 1'b1;
    else if (d <= tol && d >= -tol) ok = 1'b1;
    if (!ok) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic ticks(input int n);
    repeat (n * SC) @(posedge sys_clk);
  endtask : ticks
  task automatic start(input int hold);
    int n;
    run <= 1'b1;
    n = 0;
    while (startup_active !== 1'b1 && n < 4 * SC) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    while (startup_active === 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    check(n, (hold * 10 + 1) * SC);
  endtask : start
  function automatic int blend(int a, int b, int mode, int t, int dev);
    int w;
    int ad;
    ad = dev < 0 ? -dev : dev;
    w = (mode == 1) ? 256 * t : 0;
    if (mode == 2) w = ad < 200 * 16384 / 1000 ? 0 : ad > 800 * 16384 / 1000 ? 256 :
      (ad - 3276) * 256 / (13107 - 3276);
    return a + (b - a) * w / 256;
  endfunction : blend
  function automatic int expect_ref(int sp, int fb, int pol, int kp, int lim);
    int p;
    p = (pol != 0 ? fb - sp : sp - fb) * kp / 1000;
    if (p > 16384) p = 16384;
    if (p < -lim) p = -lim;
    return p;
  endfunction : expect_ref
  // ------------------------------------------------
  // sequence
  // ------------------------------------------------
  initial begin
    int sp, fb, md, t, ka, kb, pol, cut;
    void'($urandom(32'h44B3));
    cfg.gain_a.integ_time = 10'h3E8;
    cfg.gain_b.integ_time = 10'h3E8;
    cfg.max_freq = 16'h1388;
    cfg.switch_threshold_low = 10'h0C8;
    cfg.switch_threshold_high = 10'h320;
    cfg.deviation_deadband = 10'h3E8;
    cfg.startup_output_value = 10'h1F4;
    cfg.startup_hold_time = 16'h0001;
    setpoint = 16'h2328;
    feedback = 16'h03E8;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    start(1);
    check(freq_ref, 500 * 16384 / 1000);
    // the dead band flag only shows after the first regulated tick
    ticks(1);
    check(freq_ref, 500 * 16384 / 1000);
    check(deviation_hold, 1'b1);
    for (int i = 0; i < 16; i++) begin
      run <= 1'b0;
      ticks(3);
      sp = $urandom % 16385;
      fb = $urandom % 16385;
      md = $urandom % 4;
      t = $urandom % 2;
      ka = $urandom % 1001;
      kb = $urandom % 1001;
      pol = $urandom % 2;
      cut = $urandom % 5001;
      if (i < 3) begin
        sp = 16384;
        fb = 0;
        md = 0;
        ka = 1000;
        pol = (i != 0);
        cut = (i == 1) ? 1250 : 0;
      end
      cfg.deviation_deadband <= 10'h000;
      cfg.startup_output_value <= 10'h000;
      cfg.startup_hold_time <= 16'h0000;
      cfg.gain_switch_condition <= md[1:0];
      cfg.polarity <= pol[0];
      cfg.gain_a.prop_gain <= ka[9:0];
      cfg.gain_b.prop_gain <= kb[9:0];
      cfg.reverse_cutoff_freq <= cut[15:0];
      setpoint <= sp[15:0];
      feedback <= fb[15:0];
      want_on <= t[0];
      lag <= 4'($urandom % 16);
      ticks(1);
      start(0);
      ticks(3);
      check(freq_ref, expect_ref(sp, fb, pol, blend(ka, kb, md, t, sp - fb), cut * 16384 / 5000), 12);
      check(eff_sp, sp);
      check(filt_fb, fb);
    end
    cfg.setpoint_ramp_time <= 16'h0001;
    setpoint <= 16'h0000;
    ticks(12);
    check(eff_sp, 0);
    setpoint <= 16'h4000;
    ticks(5);
    check(eff_sp, 5 * (16384 / 10), 16384 / 10);
    ticks(8);
    check(eff_sp, 16384);
    // derivative kick, its clamp, then the output filter; restart clears the integrator
    run <= 1'b0;
    cfg.gain_switch_condition <= 2'h0;
    cfg.polarity <= 1'b0;
    cfg.gain_a.prop_gain <= 10'h000;
    cfg.gain_a.deriv_time <= 14'h000A;
    cfg.derivative_clamp <= 14'h2710;
    cfg.reverse_cutoff_freq <= 16'h1388;
    feedback <= 16'h2000;
    ticks(3);
    start(0);
    ticks(2);
    feedback <= 16'h2064;
    ticks(2);
    check(freq_ref, -1000, 3);
    cfg.derivative_clamp <= 14'h000A;
    feedback <= 16'h2000;
    ticks(2);
    check(freq_ref, 16, 6);
    cfg.gain_a.prop_gain <= 10'h3E8;
    cfg.output_filter_tc <= 13'h0001;
    ticks(1);
    check(freq_ref, 20 + (8192 - 20) / 11, 8);
    clk_en <= 1'b0;
    setpoint <= 16'h0000;
    ticks(3);
    check(eff_sp, 16384);
    clk_en <= 1'b1;
    reset <= 1'b1;
    ticks(1);
    check(freq_ref, 0);
    reset <= 1'b0;
    ticks(2);
    complete_run();
  end
  // hang guard well past the expected run of under two thousand cycles
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule : testbench
